/* File: rtl/iors_pkg.sv */
package iors_pkg;
  // word layout
  localparam int NUM_WORDS = 14;
  localparam int WORD_W = 16;
  localparam int PAYLOAD_W = 14;
  localparam int CHAN_W = 4;
  localparam int FRESH_BIT = 15;
  localparam int ALARM_BIT = 14;
  // register offsets of the output word set
  localparam logic [6:0] SUPPLY_VOLTAGE_SAMPLE = 7'h02;
  localparam logic [6:0] RATE_X_SAMPLE = 7'h04;
  localparam logic [6:0] RATE_Y_SAMPLE = 7'h06;
  localparam logic [6:0] RATE_Z_SAMPLE = 7'h08;
  localparam logic [6:0] ACCEL_X_SAMPLE = 7'h0a;
  localparam logic [6:0] ACCEL_Y_SAMPLE = 7'h0c;
  localparam logic [6:0] ACCEL_Z_SAMPLE = 7'h0e;
  localparam logic [6:0] FIELD_X_SAMPLE = 7'h10;
  localparam logic [6:0] FIELD_Y_SAMPLE = 7'h12;
  localparam logic [6:0] FIELD_Z_SAMPLE = 7'h14;
  localparam logic [6:0] PRESSURE_HIGH_WORD = 7'h16;
  localparam logic [6:0] PRESSURE_LOW_WORD = 7'h18;
  localparam logic [6:0] INTERNAL_TEMPERATURE_SAMPLE = 7'h1a;
  localparam logic [6:0] AUXILIARY_CONVERTER_SAMPLE = 7'h1c;
  localparam logic [6:0] FIRST_ADDR = SUPPLY_VOLTAGE_SAMPLE;
  localparam logic [6:0] LAST_ADDR = AUXILIARY_CONVERTER_SAMPLE;
  // serial command word fields
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam int WRITE_BIT = 15;
  localparam logic [15:0] BURST_CMD = 16'h4200;
  localparam logic [3:0] LAST_BIT = 4'hf;
  // reset values
  localparam logic [15:0] TX_RESET = 16'h0000;
  // timing
  localparam longint CLK_HZ = 125000000;
  localparam longint SAMPLE_RATE_MILLI_SPS = 819200;
  localparam longint SAMPLE_PERIOD_CYCLES = (CLK_HZ * 1000) / SAMPLE_RATE_MILLI_SPS;
  localparam longint DONE_PULSE_NS = 200;
  localparam longint DONE_PULSE_CYCLES = (DONE_PULSE_NS * CLK_HZ) / 1000000000;
  localparam int FIFO_DEPTH = 8;
  // one sample word from the sensor pipeline
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic alarm;
    logic [PAYLOAD_W-1:0] payload;
  } sample_type;
endpackage

/* File: rtl/iors_output_regs.sv */
// What this block does
// - fourteen read-only 16-bit words at even addresses 0x02 to 0x1C, latest samples.
// - bit 15 of each word reads one while the sample is new.
// - bit 14 of each word reads one while an error or alarm is active.
// - rate words at 0x04, 0x06, 0x08 carry 14-bit twos complement in 13:0.
// - rate scale is 0.05 deg/s per count at the documented range setting.
// - rate coding: -1 is 0x3FFF, +300 is 0x1770, -300 is 0x2890.
// - accel words at 0x0A, 0x0C, 0x0E, 14-bit twos complement, 3.333 mg per count.
// - accel coding: +18 g is 0x1519, -18 g is 0x2AE7, -1 is 0x3FFF.
// - field words at 0x10, 0x12, 0x14, 14-bit twos complement, 0.5 mgauss per count.
// - field coding: +2.5 gauss 0x1388, -2.5 gauss 0x2C78, -2 is 0x3FFE.
// - single read takes two 16-bit frames; address first, word returned second.
// - command 0x4200 starts a burst returning all words in ascending order.
// - words refresh at 819.2 samples per second; done pin pulses after each cycle.
`timescale 1ns/100ps

module iors_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = iors_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0] count, next_count;
  logic next_inReady;
  logic push, pop;

  // pointer and fill level update
  always_comb begin
    push = inValid & inReady;
    pop = outValid & outReady;
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    next_inReady = next_count != FULL_COUNT;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b1;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      inReady <= next_inReady;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  assign outValid = count != '0;
  assign outData = mem[rdPtr];
endmodule

module iors_output_regs #(
  parameter longint SAMPLE_PERIOD_CYCLES = iors_pkg::SAMPLE_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial link, mode 3, msb first
  input wire logic sclk,
  input wire logic chipSel_b,
  input wire logic din,
  output logic dout,
  output logic doutOe,
  // sensor pipeline
  output logic sampleStart,
  input wire logic sampleValid,
  input wire iors_pkg::sample_type sampleWord,
  output logic sampleReady,
  // sample cycle done pin
  output logic sampleDonePulsePin
);
  localparam int NW = iors_pkg::NUM_WORDS;

  // word index from a register address, and its validity
  function automatic logic addrValid(input logic [6:0] addr);
    return !addr[0] && addr >= iors_pkg::FIRST_ADDR && addr <= iors_pkg::LAST_ADDR;
  endfunction
  function automatic logic [3:0] addrIndex(input logic [6:0] addr);
    return addr[4:1] - 4'h1;
  endfunction

  // two-stage synchronisers for link pins
  logic sclkMeta, sclkSync, sclkLast, csMeta, csSync, dinMeta, dinSync;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkMeta <= 1'b1;
      sclkSync <= 1'b1;
      sclkLast <= 1'b1;
      csMeta <= 1'b1;
      csSync <= 1'b1;
      dinMeta <= 1'b0;
      dinSync <= 1'b0;
    end else begin
      sclkMeta <= sclk;
      sclkSync <= sclkMeta;
      sclkLast <= sclkSync;
      csMeta <= chipSel_b;
      csSync <= csMeta;
      dinMeta <= din;
      dinSync <= dinMeta;
    end
  end

  logic sclkRise, sclkFall;
  assign sclkRise = sclkSync & ~sclkLast;
  assign sclkFall = ~sclkSync & sclkLast;

  // output word bank
  logic [NW-1:0] fresh, alarm, next_fresh, next_alarm;
  logic [iors_pkg::PAYLOAD_W-1:0] payload [NW];
  logic [iors_pkg::PAYLOAD_W-1:0] next_payload [NW];
  logic readStrobe;
  logic [3:0] readIdx;
  logic [15:0] readWord;
  assign readWord = {fresh[readIdx], alarm[readIdx], payload[readIdx]};

  // serial engine state
  logic [3:0] bitCount, next_bitCount;
  logic [15:0] rxShift, next_rxShift, txShift, next_txShift, rxWord;
  logic next_dout, burst, next_burst, frameDone;
  logic [4:0] burstIdx, next_burstIdx;

  // shift in on rising sclk, out on falling sclk, decode at frame end
  always_comb begin
    next_bitCount = bitCount;
    next_rxShift = rxShift;
    next_txShift = txShift;
    next_dout = dout;
    next_burst = burst;
    next_burstIdx = burstIdx;
    readStrobe = 1'b0;
    readIdx = 4'h0;
    rxWord = {rxShift[14:0], dinSync};
    frameDone = 1'b0;
    if (csSync) begin
      next_bitCount = 4'h0;
      next_burst = 1'b0;
    end else begin
      if (sclkFall) begin
        next_dout = txShift[15];
        next_txShift = {txShift[14:0], 1'b0};
      end
      if (sclkRise) begin
        next_rxShift = rxWord;
        if (bitCount == iors_pkg::LAST_BIT) begin
          frameDone = 1'b1;
          next_bitCount = 4'h0;
          if (burst) begin
            if (burstIdx < 5'(NW)) begin
              readStrobe = 1'b1;
              readIdx = burstIdx[3:0];
              next_txShift = readWord;
              next_burstIdx = burstIdx + 5'h01;
            end else begin
              next_burst = 1'b0;
              next_txShift = iors_pkg::TX_RESET;
            end
          end else if (rxWord == iors_pkg::BURST_CMD) begin
            readStrobe = 1'b1;
            readIdx = 4'h0;
            next_txShift = readWord;
            next_burst = 1'b1;
            next_burstIdx = 5'h01;
          end else if (!rxWord[iors_pkg::WRITE_BIT] &&
                       addrValid(rxWord[iors_pkg::ADDR_MSB:iors_pkg::ADDR_LSB])) begin
            readStrobe = 1'b1;
            readIdx = addrIndex(rxWord[iors_pkg::ADDR_MSB:iors_pkg::ADDR_LSB]);
            next_txShift = readWord;
          end else begin
            next_txShift = iors_pkg::TX_RESET;
          end
        end else begin
          next_bitCount = bitCount + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bitCount <= 4'h0;
      rxShift <= 16'h0000;
      txShift <= iors_pkg::TX_RESET;
      dout <= 1'b0;
      doutOe <= 1'b0;
      burst <= 1'b0;
      burstIdx <= 5'h00;
    end else begin
      bitCount <= next_bitCount;
      rxShift <= next_rxShift;
      txShift <= next_txShift;
      dout <= next_dout;
      doutOe <= ~csSync;
      burst <= next_burst;
      burstIdx <= next_burstIdx;
    end
  end

  // sample fifo between the sensor pipeline and the bank
  iors_pkg::sample_type drainWord;
  logic drainValid, drainReady, drainFire;
  logic [3:0] drainChan;
  logic drainAlarm;
  logic [iors_pkg::PAYLOAD_W-1:0] drainPayload;
  assign drainReady = ~readStrobe; // a read strobe holds the bank still for its one cycle
  assign drainFire = drainValid & drainReady;
  assign drainChan = drainWord.chan;
  assign drainAlarm = drainWord.alarm;
  assign drainPayload = drainWord.payload;

  iors_fifo #(
    .WIDTH($bits(iors_pkg::sample_type)),
    .DEPTH(iors_pkg::FIFO_DEPTH)
  ) sampleFifo (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(sampleValid),
    .inData(sampleWord),
    .inReady(sampleReady),
    .outValid(drainValid),
    .outData(drainWord),
    .outReady(drainReady)
  );

  // bank update: read clears fresh, a new sample sets it and wins
  always_comb begin
    next_fresh = fresh;
    next_alarm = alarm;
    next_payload = payload;
    if (readStrobe) begin
      next_fresh[readIdx] = 1'b0;
    end
    if (drainFire && drainChan < 4'(NW)) begin
      next_fresh[drainChan] = 1'b1;
      next_alarm[drainChan] = drainAlarm;
      next_payload[drainChan] = drainPayload;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fresh <= '0;
      alarm <= '0;
      for (int i = 0; i < NW; i++) begin
        payload[i] <= '0;
      end
    end else begin
      fresh <= next_fresh;
      alarm <= next_alarm;
      payload <= next_payload;
    end
  end

  // sample period timer and done pulse
  logic [31:0] periodCount, next_periodCount;
  logic [15:0] doneCount, next_doneCount;
  logic next_sampleStart;
  always_comb begin
    next_sampleStart = 1'b0;
    next_periodCount = periodCount + 32'h1;
    if (periodCount >= 32'(SAMPLE_PERIOD_CYCLES - 1)) begin
      next_periodCount = 32'h0;
      next_sampleStart = 1'b1;
    end
    next_doneCount = (doneCount != 16'h0) ? doneCount - 16'h1 : 16'h0;
    if (drainFire && drainChan == 4'(NW - 1)) begin
      next_doneCount = 16'(iors_pkg::DONE_PULSE_CYCLES);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      periodCount <= 32'h0;
      doneCount <= 16'h0;
      sampleStart <= 1'b0;
      sampleDonePulsePin <= 1'b0;
    end else begin
      periodCount <= next_periodCount;
      doneCount <= next_doneCount;
      sampleStart <= next_sampleStart;
      sampleDonePulsePin <= next_doneCount != 16'h0;
    end
  end

  // checks
  AST_FRESH_SET: assert property (@(posedge clk) disable iff (!rst_b)
    drainFire && drainChan < 4'(NW) |=> fresh[$past(drainChan)])
    else $error("fresh flag not set by new sample");
  AST_FRESH_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    readStrobe && !(drainFire && drainChan == readIdx) |=> !fresh[$past(readIdx)])
    else $error("fresh flag not cleared by read");
  AST_ALARM_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
    drainFire && drainChan < 4'(NW) |=> alarm[$past(drainChan)] == $past(drainAlarm))
    else $error("alarm flag not loaded with sample");
  AST_PAYLOAD_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
    drainFire && drainChan < 4'(NW) |=> payload[$past(drainChan)] == $past(drainPayload))
    else $error("payload not loaded");
  AST_READ_WORD: assert property (@(posedge clk) disable iff (!rst_b)
    readStrobe |=> txShift == $past(readWord))
    else $error("read word not loaded whole");
  AST_BURST_START: assert property (@(posedge clk) disable iff (!rst_b)
    frameDone && !burst && rxWord == iors_pkg::BURST_CMD |=> burst && burstIdx == 5'h01)
    else $error("burst not started");
  AST_BAD_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
    frameDone && !burst && rxWord != iors_pkg::BURST_CMD && !readStrobe |=> txShift == 16'h0000)
    else $error("unmapped address did not return zero");
  AST_DOUT_MSB: assert property (@(posedge clk) disable iff (!rst_b)
    sclkFall && !csSync |=> dout == $past(txShift[15]))
    else $error("dout not msb of shifter");
  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    drainFire && drainChan == 4'(NW - 1) |=> sampleDonePulsePin [*8])
    else $error("done pulse too short");
  COV_BURST: cover property (@(posedge clk) disable iff (!rst_b) burst && frameDone);
  COV_SINGLE: cover property (@(posedge clk) disable iff (!rst_b) readStrobe && !burst);
  COV_FIFO_FULL: cover property (@(posedge clk) disable iff (!rst_b) !sampleReady);
  COV_SET_AND_CLEAR: cover property (@(posedge clk) disable iff (!rst_b)
    readStrobe && drainValid);
endmodule

/* File: bench/iors_spi_master.sv */
`timescale 1ns/100ps

module iors_spi_master (
  // drive timing
  input wire logic clk,
  // serial link
  output logic sclk,
  output logic chipSel_b,
  output logic din,
  input wire logic dout
);
  // half of the 80 ns serial period in system clocks
  localparam int HALF_CLKS = 5;

  // link idles with clock high and device released
  initial begin
    sclk = 1'b1;
    chipSel_b = 1'b1;
    din = 1'b0;
  end

  // move to just after a system clock edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // select the device, clock stays high
  task automatic select();
    step(1);
    chipSel_b = 1'b0;
    step(HALF_CLKS);
  endtask

  // release the device; data line no longer shows its last bit
  task automatic deselect();
    step(HALF_CLKS);
    chipSel_b = 1'b1;
    din = ~din;
  endtask

  // one 16-bit full duplex frame, msb first, data taken before the rising edge
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];
      step(HALF_CLKS);
      rx[i] = dout;
      sclk = 1'b1;
      step(HALF_CLKS);
    end
    step(HALF_CLKS);
  endtask
endmodule

/* File: bench/iors_output_regs_tb.sv */
`timescale 1ns/100ps

module iors_output_regs_tb;
  localparam longint PERIOD = 200;
  typedef struct {
    logic [3:0] chan;
    logic alarm;
    logic [13:0] payload;
    logic [15:0] expWord;
  } iors_row_type;

  logic clk;
  logic rst_b;
  logic sampleValid;
  iors_pkg::sample_type sampleWord;
  logic sclk, chipSel_b, din, dout, doutOe, sampleStart, sampleReady, sampleDonePulsePin;
  int badCount = 0;
  int samplesChecked = 0;
  int pulseLen = 0;
  int lastPulse = 0;
  logic [15:0] req[$];
  logic [15:0] exp[$];
  int n;
  // one sample per channel, coded values beside the word they read back as
  iors_row_type rows[14] = '{
    '{4'h0, 1'b1, 14'h0814, 16'hc814}, '{4'h1, 1'b0, 14'h1770, 16'h9770},
    '{4'h2, 1'b0, 14'h2890, 16'ha890}, '{4'h3, 1'b0, 14'h3fff, 16'hbfff},
    '{4'h4, 1'b0, 14'h1519, 16'h9519}, '{4'h5, 1'b0, 14'h2ae7, 16'haae7},
    '{4'h6, 1'b0, 14'h3fff, 16'hbfff}, '{4'h7, 1'b0, 14'h1388, 16'h9388},
    '{4'h8, 1'b0, 14'h2c78, 16'hac78}, '{4'h9, 1'b0, 14'h3ffe, 16'hbffe},
    '{4'ha, 1'b0, 14'h35b6, 16'hb5b6}, '{4'hb, 1'b0, 14'h00ab, 16'h80ab},
    '{4'hc, 1'b0, 14'h0fff, 16'h8fff}, '{4'hd, 1'b1, 14'h04d9, 16'hc4d9}};

  // 125 MHz system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  iors_output_regs #(.SAMPLE_PERIOD_CYCLES(PERIOD)) dut_u (
    .clk(clk), .rst_b(rst_b), .sclk(sclk), .chipSel_b(chipSel_b), .din(din),
    .dout(dout), .doutOe(doutOe), .sampleStart(sampleStart), .sampleValid(sampleValid),
    .sampleWord(sampleWord), .sampleReady(sampleReady),
    .sampleDonePulsePin(sampleDonePulsePin));

  iors_spi_master mst_u (
    .clk(clk), .sclk(sclk), .chipSel_b(chipSel_b), .din(din), .dout(dout));

  // width of the last done pulse, sampled mid-cycle where the pin is settled
  always @(negedge clk) begin
    if (sampleDonePulsePin === 1'b1) begin
      pulseLen <= pulseLen + 1;
    end else if (pulseLen != 0) begin
      lastPulse <= pulseLen;
      pulseLen <= 0;
    end
  end

  // verdict and end of run
  task automatic wrapUp();
    if (badCount == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    samplesChecked++;
    if (got !== want) begin
      badCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, want);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // wait for a level on one of the design's flags, bounded; looks just after each edge
  task automatic waitFor(ref logic sig, input logic lvl);
    for (n = 0; n < 1000 && sig !== lvl; n++) step(1);
    if (n == 1000) begin
      badCount++;
      $display("[ERR] %0t wait ran out", $time);
      wrapUp();
    end
  endtask

  // offer one word and hold it until the edge that takes it
  task automatic push(input iors_row_type r);
    sampleValid = 1'b1;
    sampleWord = '{r.chan, r.alarm, r.payload};
    @(posedge clk);
    while (sampleReady !== 1'b1) @(posedge clk);
    #1;
  endtask

  task automatic pushAll();
    step(1);
    foreach (rows[i]) push(rows[i]);
    sampleValid = 1'b0;
    step(4);
  endtask

  // frames in one selection; each answer checked against the word asked one frame earlier
  task automatic readSeq(input logic [15:0] rq[$], input logic [15:0] ex[$]);
    logic [15:0] rx;
    mst_u.select();
    chk({15'h0, doutOe}, 16'h0001);
    foreach (rq[i]) begin
      mst_u.xfer(rq[i], rx);
      if (i > 0) chk(rx, ex[i-1]);
    end
    mst_u.deselect();
    step(4);
    chk({15'h0, doutOe}, 16'h0000);
  endtask

  initial begin
    rst_b = 1'b0;
    sampleValid = 1'b0;
    sampleWord = '0;
    step(8);
    rst_b = 1'b1;
    step(4);
    // spacing of sample cycle requests
    waitFor(sampleStart, 1'b1);
    step(1);
    for (n = 1; n < 1000 && sampleStart !== 1'b1; n++) step(1);
    chk(16'(n), 16'(PERIOD));
    // load every word, then the done pin pulses
    pushAll();
    waitFor(sampleDonePulsePin, 1'b1);
    waitFor(sampleDonePulsePin, 1'b0);
    step(2);
    chk(16'(lastPulse), 16'(iors_pkg::DONE_PULSE_CYCLES));
    // pipelined single reads of all rows
    foreach (rows[i]) begin
      req.push_back({1'b0, 7'(2 + 2 * rows[i].chan), 8'h00});
      exp.push_back(rows[i].expWord);
    end
    req.push_back(16'h0000);
    readSeq(req, exp);
    // a channel beyond the last word is dropped; first read finds fresh cleared, second finds it set again
    push('{4'he, 1'b1, 14'h1234, 16'h0000});
    sampleValid = 1'b0;
    step(4);
    readSeq('{16'h0400, 16'h0000}, '{16'h1770});
    push('{4'h1, 1'b1, 14'h0002, 16'h0000});
    sampleValid = 1'b0;
    step(4);
    readSeq('{16'h0400, 16'h0000}, '{16'hc002});
    // odd, out of range and write frames answer zero
    readSeq('{16'h0500, 16'h1e00, 16'h8400, 16'h0000}, '{16'h0, 16'h0, 16'h0});
    // burst of all words in ascending order, then zero
    pushAll();
    req = '{16'h4200};
    repeat (15) req.push_back(16'h0000);
    exp.push_back(16'h0000);
    readSeq(req, exp);
    // reset in mid-run idles the pins and clears the word at 0x04
    rst_b = 1'b0;
    step(2);
    chk({12'h0, doutOe, sampleStart, sampleReady, sampleDonePulsePin}, 16'h0002);
    rst_b = 1'b1;
    step(4);
    readSeq('{16'h0400, 16'h0000}, '{16'h0000});
    wrapUp();
  end
endmodule
